// ### hw/csfr_pkg.sv
package csfr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  CSFR_OFS_FLAG   = 4'h0;
  localparam logic [3:0]  CSFR_OFS_EVENT  = 4'h4;
  localparam logic [3:0]  CSFR_OFS_MASK   = 4'h8;
  localparam logic [3:0]  CSFR_OFS_RESULT = 4'hC;

  // ----------------------------------------------------------------
  // Flag register layout
  // ----------------------------------------------------------------
  localparam int unsigned CSFR_B_CARRY    = 0;
  localparam int unsigned CSFR_B_NIB      = 1;
  localparam int unsigned CSFR_B_NULL     = 2;
  localparam int unsigned CSFR_B_SLEEP    = 3;
  localparam int unsigned CSFR_B_EXPIRY   = 4;
  localparam int unsigned CSFR_B_SEG_LO   = 5;
  localparam int unsigned CSFR_B_SEG_HI   = 6;
  localparam logic [7:0]  CSFR_FLAG_RST   = 8'h18;
  localparam logic [7:0]  CSFR_SW_MASK    = 8'hE7;
  localparam logic [7:0]  CSFR_ALU_MASK   = 8'h07;

  // ----------------------------------------------------------------
  // Event and mask registers
  // ----------------------------------------------------------------
  localparam int unsigned CSFR_EV_W        = 3;
  localparam int unsigned CSFR_EV_EXPIRY   = 0;
  localparam int unsigned CSFR_EV_SLEEP    = 1;
  localparam int unsigned CSFR_EV_OVERRIDE = 2;
  localparam logic [2:0]  CSFR_EV_RST      = 3'h0;
  localparam logic [2:0]  CSFR_MASK_RST    = 3'h0;

  // ----------------------------------------------------------------
  // Operation codes and bus states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CSFR_OP_NONE  = 4'h0,
    CSFR_OP_ADD   = 4'h1,
    CSFR_OP_SUB   = 4'h2,
    CSFR_OP_AND   = 4'h3,
    CSFR_OP_IOR   = 4'h4,
    CSFR_OP_XOR   = 4'h5,
    CSFR_OP_ROR   = 4'h6,
    CSFR_OP_ROL   = 4'h7,
    CSFR_OP_ZERO  = 4'h8,
    CSFR_OP_BCLR  = 4'h9,
    CSFR_OP_BSET  = 4'hA,
    CSFR_OP_STORE = 4'hB,
    CSFR_OP_KICK  = 4'hC,
    CSFR_OP_SLEEP = 4'hD
  } csfr_op_type;

  typedef enum logic [1:0] {
    CSFR_BS_IDLE = 2'b01,
    CSFR_BS_ACK  = 2'b10
  } csfr_bus_state_type;

endpackage

// ### hw/csfr_if.sv
`timescale 1ns/10ps
interface csfr_alu_if;
  import csfr_pkg::*;
  csfr_op_type op;
  logic [7:0]  reg_val;
  logic [7:0]  acc_val;
  logic [2:0]  bit_idx;
  logic        carry_in;
  logic [7:0]  result;
  logic        null_out;
  logic        nib_out;
  logic        carry_out;
  logic        upd_null;
  logic        upd_nib;
  logic        upd_carry;
  logic        writes_result;
  modport core (output op, reg_val, acc_val, bit_idx, carry_in,
                input result, null_out, nib_out, carry_out, upd_null, upd_nib,
                upd_carry, writes_result);
  modport alu  (input op, reg_val, acc_val, bit_idx, carry_in,
                output result, null_out, nib_out, carry_out, upd_null, upd_nib,
                upd_carry, writes_result);
endinterface

interface csfr_bus_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr_pulse;
  logic [7:0] rdata;
  logic       hold;
  modport slave (output addr, wdata, wr_pulse, input rdata, hold);
  modport regs  (input addr, wdata, wr_pulse, output rdata, hold);
endinterface

// ### hw/csfr_flag_alu.sv
`timescale 1ns/10ps
module csfr_flag_alu
  import csfr_pkg::*;
(
  csfr_alu_if.alu a
);

  logic [8:0] sum9;
  logic [4:0] nib5;

  always_comb begin
    sum9            = 9'h000;
    nib5            = 5'h00;
    a.result        = 8'h00;
    a.nib_out       = 1'b0;
    a.carry_out     = a.carry_in;
    a.upd_null      = 1'b0;
    a.upd_nib       = 1'b0;
    a.upd_carry     = 1'b0;
    a.writes_result = 1'b1;
    case (a.op)
      CSFR_OP_ADD, CSFR_OP_SUB: begin
        // Subtract as add of the inverted operand plus one
        if (a.op == CSFR_OP_ADD) begin
          sum9 = {1'b0, a.reg_val} + {1'b0, a.acc_val};
          nib5 = {1'b0, a.reg_val[3:0]} + {1'b0, a.acc_val[3:0]};
        end else begin
          sum9 = {1'b0, a.reg_val} + {1'b0, ~a.acc_val} + 9'h001;
          nib5 = {1'b0, a.reg_val[3:0]} + {1'b0, ~a.acc_val[3:0]} + 5'h01;
        end
        a.result    = sum9[7:0];
        a.nib_out   = nib5[4];                                         // R11
        a.carry_out = sum9[8];                                         // R12
        a.upd_null  = 1'b1;
        a.upd_nib   = 1'b1;
        a.upd_carry = 1'b1;
      end
      CSFR_OP_AND: begin
        a.result   = a.reg_val & a.acc_val;
        a.upd_null = 1'b1;
      end
      CSFR_OP_IOR: begin
        a.result   = a.reg_val | a.acc_val;
        a.upd_null = 1'b1;
      end
      CSFR_OP_XOR: begin
        a.result   = a.reg_val ^ a.acc_val;
        a.upd_null = 1'b1;
      end
      CSFR_OP_ROR: begin
        a.result    = {a.carry_in, a.reg_val[7:1]};
        a.carry_out = a.reg_val[0];                                    // R13
        a.upd_carry = 1'b1;
      end
      CSFR_OP_ROL: begin
        a.result    = {a.reg_val[6:0], a.carry_in};
        a.carry_out = a.reg_val[7];                                    // R13
        a.upd_carry = 1'b1;
      end
      CSFR_OP_ZERO: begin
        a.result   = 8'h00;
        a.upd_null = 1'b1;
      end
      CSFR_OP_BCLR: a.result = a.reg_val & ~(8'h01 << a.bit_idx);   // R6
      CSFR_OP_BSET: a.result = a.reg_val | (8'h01 << a.bit_idx);    // R6
      CSFR_OP_STORE: a.result = a.acc_val;                            // R6
      default: a.writes_result = 1'b0;
    endcase
  end

  assign a.null_out = (a.result == 8'h00);                             // R10

endmodule

// ### hw/csfr_bus_slave.sv
`timescale 1ns/10ps
module csfr_bus_slave
  import csfr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  csfr_bus_if.slave        b
);

  csfr_bus_state_type state_q, state_d;
  logic        wait_q, wait_d;
  logic [31:0] rdat_q, rdat_d;

  always_comb begin
    state_d = state_q;
    wait_d  = 1'b1;
    rdat_d  = rdat_q;
    case (state_q)
      CSFR_BS_IDLE: begin
        // Answer one cycle after the request, unless the core holds us
        if ((avs_read || avs_write) && !b.hold) begin
          state_d = CSFR_BS_ACK;
          wait_d  = 1'b0;
          rdat_d  = {24'h00_0000, b.rdata};
        end
      end
      CSFR_BS_ACK: state_d = CSFR_BS_IDLE;
      default:     state_d = CSFR_BS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= CSFR_BS_IDLE;
      wait_q  <= 1'b1;
      rdat_q  <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      rdat_q  <= rdat_d;
    end
  end

  assign b.addr          = avs_address;
  assign b.wdata         = avs_writedata[7:0];
  assign b.wr_pulse      = (state_q == CSFR_BS_ACK) && avs_write && avs_byteenable[0];
  assign avs_readdata    = rdat_q;
  assign avs_waitrequest = wait_q;

endmodule

// ### hw/csfr_top.sv
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
// Operation
// [R1] Flag register may be any instruction's destination
// [R2] Flag-affecting ops override written result bits
// [R3] Software writes never change expiry/sleep flags
// [R4] Zero op clears segment, sets null, keeps rest
// [R5] Software should alter flags via clear/set/store
// [R6] Clear, set, store leave ALU flags alone
// [R7] Bits 7-5 segment select; bits 6-5 choose page
// [R8] Expiry flag set on power-up/kick/sleep, cleared on expiry
// [R9] Sleep flag set on power-up/kick, cleared on sleep
// [R10] Null flag marks all-zero ALU result
// [R11] Nibble overflow is carry/no-borrow from bit 3
// [R12] Carry is carry-out or no-borrow
// [R13] Rotates load carry with shifted-out bit
// [R14] Reset clears segment, sets expiry and sleep flags
module csfr_top
  import csfr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        op_valid,
  input  wire csfr_op_type op_code,
  input  wire logic [7:0]  op_reg,
  input  wire logic [7:0]  op_acc,
  input  wire logic [2:0]  op_bit,
  input  wire logic        op_dest_flag,
  input  wire logic        watchdog_expire,
  output logic      [7:0]  cpu_flag_register,
  output logic      [1:0]  rom_segment_select,
  output logic      [7:0]  op_result,
  output logic             op_done,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  csfr_alu_if alu_c ();
  csfr_bus_if bus_c ();

  csfr_flag_alu u_alu (
    .a (alu_c.alu)
  );

  csfr_bus_slave u_bus (
    .clk_sys         (clk_sys),
    .resetn          (resetn),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .b               (bus_c.slave)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]           flag_q, flag_d;
  logic [CSFR_EV_W-1:0] evt_q, evt_d;
  logic [CSFR_EV_W-1:0] mask_q, mask_d;
  logic                 irq_q, irq_d;
  logic [7:0]           res_q, res_d;
  logic                 done_q, done_d;
  logic [7:0]           wmask;
  logic [CSFR_EV_W-1:0] evt_set;
  logic [CSFR_EV_W-1:0] evt_clr;
  logic                 any_upd;
  logic                 sw_flag_wr;

  assign alu_c.op       = op_valid ? op_code : CSFR_OP_NONE;
  assign alu_c.reg_val  = op_reg;
  assign alu_c.acc_val  = op_acc;
  assign alu_c.bit_idx  = op_bit;
  assign alu_c.carry_in = flag_q[CSFR_B_CARRY];
  assign any_upd        = alu_c.upd_null | alu_c.upd_nib | alu_c.upd_carry;
  assign sw_flag_wr     = bus_c.wr_pulse && (bus_c.addr == CSFR_OFS_FLAG);

  // Core operations take the cycle; a bus request waits in IDLE, but a flag write already in ACK is lost
  assign bus_c.hold = op_valid;

  // ----------------------------------------------------------------
  // Flag register
  // ----------------------------------------------------------------
  always_comb begin
    flag_d  = flag_q;
    wmask   = CSFR_SW_MASK;                                           // R3
    evt_set = CSFR_EV_RST;
    if (op_valid) begin
      if (any_upd) begin
        wmask = CSFR_SW_MASK & ~CSFR_ALU_MASK;                        // R2
      end
      if (alu_c.writes_result && op_dest_flag) begin
        flag_d = (flag_q & ~wmask) | (alu_c.result & wmask);          // R1
        if (any_upd) begin
          evt_set[CSFR_EV_OVERRIDE] = 1'b1;                           // R2
        end
      end
      if (alu_c.upd_null) begin
        flag_d[CSFR_B_NULL] = alu_c.null_out;                         // R4
      end
      if (alu_c.upd_nib) begin
        flag_d[CSFR_B_NIB] = alu_c.nib_out;                           // R11
      end
      if (alu_c.upd_carry) begin
        flag_d[CSFR_B_CARRY] = alu_c.carry_out;                       // R12
      end
      if (op_code == CSFR_OP_KICK) begin
        flag_d[CSFR_B_EXPIRY] = 1'b1;                                 // R8
        flag_d[CSFR_B_SLEEP]  = 1'b1;                                 // R9
      end
      if (op_code == CSFR_OP_SLEEP) begin
        flag_d[CSFR_B_EXPIRY] = 1'b1;                                 // R8
        flag_d[CSFR_B_SLEEP]  = 1'b0;                                 // R9
        evt_set[CSFR_EV_SLEEP] = 1'b1;
      end
    end else if (sw_flag_wr) begin
      // Bus write behaves as a store into the flag register
      flag_d = (flag_q & ~CSFR_SW_MASK) | (bus_c.wdata & CSFR_SW_MASK); // R3
    end
    if (watchdog_expire) begin
      flag_d[CSFR_B_EXPIRY] = 1'b0;                                   // R8
      evt_set[CSFR_EV_EXPIRY] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      flag_q <= CSFR_FLAG_RST;                                        // R14
    end else begin
      flag_q <= flag_d;
    end
  end

  assign cpu_flag_register  = flag_q;
  assign rom_segment_select = flag_q[CSFR_B_SEG_HI:CSFR_B_SEG_LO];    // R7

  // ----------------------------------------------------------------
  // Events, mask and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    evt_clr = CSFR_EV_RST;
    mask_d  = mask_q;
    if (bus_c.wr_pulse && (bus_c.addr == CSFR_OFS_EVENT)) begin
      evt_clr = bus_c.wdata[CSFR_EV_W-1:0];
    end
    if (bus_c.wr_pulse && (bus_c.addr == CSFR_OFS_MASK)) begin
      mask_d = bus_c.wdata[CSFR_EV_W-1:0];
    end
    // Set wins over a clear in the same cycle
    evt_d = (evt_q & ~evt_clr) | evt_set;
    irq_d = |(evt_d & mask_d);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      evt_q  <= CSFR_EV_RST;
      mask_q <= CSFR_MASK_RST;
      irq_q  <= 1'b0;
    end else begin
      evt_q  <= evt_d;
      mask_q <= mask_d;
      irq_q  <= irq_d;
    end
  end

  assign irq = irq_q;

  // ----------------------------------------------------------------
  // Operation result
  // ----------------------------------------------------------------
  always_comb begin
    res_d  = res_q;
    done_d = 1'b0;
    if (op_valid && alu_c.writes_result) begin
      res_d  = alu_c.result;
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      res_q  <= 8'h00;
      done_q <= 1'b0;
    end else begin
      res_q  <= res_d;
      done_q <= done_d;
    end
  end

  assign op_result = res_q;
  assign op_done   = done_q;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    case (bus_c.addr)
      CSFR_OFS_FLAG:   bus_c.rdata = flag_q;
      CSFR_OFS_EVENT:  bus_c.rdata = {5'h00, evt_q};
      CSFR_OFS_MASK:   bus_c.rdata = {5'h00, mask_q};
      CSFR_OFS_RESULT: bus_c.rdata = res_q;
      default:         bus_c.rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TO_PD_SW_RO: assert property (@(posedge clk_sys) disable iff (!resetn) // R3
    (sw_flag_wr && !op_valid && !watchdog_expire)
    |=> flag_q[4:3] == $past(flag_q[4:3]))
    else $error("software write changed expiry or sleep flag");

  AST_ADD_MASKED: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
    (op_valid && op_code == CSFR_OP_ADD && op_dest_flag && !watchdog_expire)
    |=> (flag_q[7:5] == 3'(($past(op_reg) + $past(op_acc)) >> 5))
        && (flag_q[4:3] == $past(flag_q[4:3]))
        && (flag_q[0] == ($past(op_reg) + $past(op_acc) > 9'h0FF)))
    else $error("add into flag register not masked");

  AST_ZERO_OP: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
    (op_valid && op_code == CSFR_OP_ZERO && op_dest_flag && !watchdog_expire)
    |=> (flag_q[7:5] == 3'h0) && flag_q[CSFR_B_NULL]
        && (flag_q[4:3] == $past(flag_q[4:3]))
        && (flag_q[1:0] == $past(flag_q[1:0])))
    else $error("zero op on flag register wrong");

  AST_STORE_FULL: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
    (op_valid && op_code == CSFR_OP_STORE && op_dest_flag)
    |=> (flag_q & CSFR_SW_MASK) == ($past(op_acc) & CSFR_SW_MASK))
    else $error("store into flag register lost bits");

  AST_BSET_KEEP: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
    (op_valid && op_code == CSFR_OP_BSET && !op_dest_flag)
    |=> flag_q == $past(flag_q) || $past(watchdog_expire))
    else $error("bit set altered flags");

  AST_SUB_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn) // R12
    (op_valid && op_code == CSFR_OP_SUB && !op_dest_flag)
    |=> flag_q[CSFR_B_CARRY] == ($past(op_reg) >= $past(op_acc)))
    else $error("subtract carry wrong");

  AST_ROR_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    (op_valid && op_code == CSFR_OP_ROR && !op_dest_flag)
    |=> flag_q[CSFR_B_CARRY] == (($past(op_reg) & 8'h01) != 8'h00))
    else $error("rotate right carry wrong");

  AST_SLEEP_FLAGS: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
    (op_valid && op_code == CSFR_OP_SLEEP && !watchdog_expire)
    |=> flag_q[CSFR_B_EXPIRY] && !flag_q[CSFR_B_SLEEP] && evt_q[CSFR_EV_SLEEP])
    else $error("sleep did not update flags");

  AST_EXPIRY: assert property (@(posedge clk_sys) disable iff (!resetn) // R8
    watchdog_expire |=> !flag_q[CSFR_B_EXPIRY] && evt_q[CSFR_EV_EXPIRY])
    else $error("watchdog expiry not recorded");

  AST_SEG_PAGE: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
    $changed(rom_segment_select) |-> $past(op_valid) || $past(sw_flag_wr))
    else $error("segment select changed without a write");

  AST_KICK_FLAGS: assert property (@(posedge clk_sys) disable iff (!resetn) // R8
    (op_valid && op_code == CSFR_OP_KICK && !watchdog_expire)
    |=> flag_q[CSFR_B_EXPIRY] && flag_q[CSFR_B_SLEEP])
    else $error("kick did not set expiry and sleep flags");

  AST_ADD_NIB: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
    (op_valid && op_code == CSFR_OP_ADD && !op_dest_flag)
    |=> flag_q[CSFR_B_NIB] == ($past(op_reg[3:0]) + $past(op_acc[3:0]) > 5'h0F))
    else $error("add nibble overflow wrong");

  AST_ROL_CARRY: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
    (op_valid && op_code == CSFR_OP_ROL && !op_dest_flag)
    |=> flag_q[CSFR_B_CARRY] == $past(op_reg[7]))
    else $error("rotate left carry wrong");

  AST_AND_NULL: assert property (@(posedge clk_sys) disable iff (!resetn) // R10
    (op_valid && op_code == CSFR_OP_AND && !op_dest_flag)
    |=> flag_q[CSFR_B_NULL] == (($past(op_reg) & $past(op_acc)) == 8'h00))
    else $error("logic op null flag wrong");

endmodule

// ### verification/test_cpu_status_flag_register.sv
`timescale 1ns/10ps
module test_cpu_status_flag_register
  import csfr_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk_sys = 1'b0;
  logic        resetn  = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        op_valid = 1'b0;
  csfr_op_type op_code = CSFR_OP_NONE;
  logic [7:0]  op_reg = 8'h00;
  logic [7:0]  op_acc = 8'h00;
  logic [2:0]  op_bit = 3'h0;
  logic        op_dest_flag = 1'b0;
  logic        watchdog_expire = 1'b0;
  logic [7:0]  cpu_flag_register;
  logic [1:0]  rom_segment_select;
  logic [7:0]  op_result;
  logic        op_done;
  logic        irq;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic [7:0]  exp_flag = 8'h18;
  logic [7:0]  exp_res = 8'h00;
  logic [2:0]  exp_ev = 3'h0;
  logic [7:0]  wvals [7] = '{8'hFF, 8'h00, 8'hA5, 8'h40, 8'h20, 8'hE7, 8'h80};

  csfr_top dut (
    .clk_sys            (clk_sys),
    .resetn             (resetn),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .op_valid           (op_valid),
    .op_code            (op_code),
    .op_reg             (op_reg),
    .op_acc             (op_acc),
    .op_bit             (op_bit),
    .op_dest_flag       (op_dest_flag),
    .watchdog_expire    (watchdog_expire),
    .cpu_flag_register  (cpu_flag_register),
    .rom_segment_select (rom_segment_select),
    .op_result          (op_result),
    .op_done            (op_done),
    .irq                (irq)
  );

  always #10 clk_sys = ~clk_sys;

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Bus and operation drivers
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write      <= w;
    avs_read       <= ~w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(rd, {24'h00_0000, exp});
  endtask

  task automatic do_op(input csfr_op_type c, input logic [7:0] r, input logic [7:0] a,
                       input logic [2:0] b, input logic dst);
    logic [8:0] s;
    logic [7:0] res;
    logic [2:0] aff;
    logic       dc;
    logic       cy;
    logic       hasr;
    dc   = 1'b0;
    cy   = 1'b0;
    aff  = 3'b000;
    hasr = 1'b1;
    res  = 8'h00;
    case (c)
      CSFR_OP_ADD: begin
        s   = {1'b0, r} + {1'b0, a};
        res = s[7:0];
        cy  = s[8];
        dc  = ({1'b0, r[3:0]} + {1'b0, a[3:0]}) > 5'h0F;
        aff = 3'b111;
      end
      CSFR_OP_SUB: begin
        res = r - a;
        cy  = r >= a;
        dc  = r[3:0] >= a[3:0];
        aff = 3'b111;
      end
      CSFR_OP_AND: begin res = r & a; aff = 3'b100; end
      CSFR_OP_IOR: begin res = r | a; aff = 3'b100; end
      CSFR_OP_XOR: begin res = r ^ a; aff = 3'b100; end
      CSFR_OP_ROR: begin res = {exp_flag[0], r[7:1]}; cy = r[0]; aff = 3'b001; end
      CSFR_OP_ROL: begin res = {r[6:0], exp_flag[0]}; cy = r[7]; aff = 3'b001; end
      CSFR_OP_ZERO: aff = 3'b100;
      CSFR_OP_BCLR: res = r & ~(8'h01 << b);
      CSFR_OP_BSET: res = r | (8'h01 << b);
      CSFR_OP_STORE: res = a;
      CSFR_OP_KICK: begin exp_flag[4:3] = 2'b11; hasr = 1'b0; end
      CSFR_OP_SLEEP: begin exp_flag[4:3] = 2'b10; exp_ev[1] = 1'b1; hasr = 1'b0; end
      default: hasr = 1'b0;
    endcase
    if (dst && hasr) begin
      exp_flag = (exp_flag & ((aff != 3'b000) ? 8'h1F : 8'h18)) |
                 (res & ((aff != 3'b000) ? 8'hE0 : 8'hE7));
      if (aff != 3'b000) exp_ev[2] = 1'b1;
    end
    if (aff[2]) exp_flag[2] = (res == 8'h00);
    if (aff[1]) exp_flag[1] = dc;
    if (aff[0]) exp_flag[0] = cy;
    if (hasr) exp_res = res;
    @(posedge clk_sys);
    op_code      <= c;
    op_reg       <= r;
    op_acc       <= a;
    op_bit       <= b;
    op_dest_flag <= dst;
    op_valid     <= 1'b1;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk(op_done, hasr);
    chk(cpu_flag_register, exp_flag);
    chk(op_result, exp_res);
  endtask

  task automatic wdog;
    @(posedge clk_sys);
    watchdog_expire <= 1'b1;
    exp_flag[4] = 1'b0;
    exp_ev[0]   = 1'b1;
    @(posedge clk_sys);
    watchdog_expire <= 1'b0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    #1;
    chk(cpu_flag_register, 8'h18);
    chk(rom_segment_select, 2'b00);
    chk(irq, 1'b0);
    rd_chk(CSFR_OFS_FLAG, 8'h18);
    rd_chk(CSFR_OFS_EVENT, 8'h00);
    rd_chk(CSFR_OFS_MASK, 8'h00);
    foreach (wvals[i]) begin
      bus(1'b1, CSFR_OFS_FLAG, wvals[i], 4'h1);
      exp_flag = (wvals[i] & 8'hE7) | (exp_flag & 8'h18);
      chk(cpu_flag_register, exp_flag);
      chk(rom_segment_select, wvals[i][6:5]);
      rd_chk(CSFR_OFS_FLAG, exp_flag);
    end
    bus(1'b1, CSFR_OFS_FLAG, 8'h00, 4'h0);
    rd_chk(CSFR_OFS_FLAG, exp_flag);
    bus(1'b1, 4'h2, 8'hFF, 4'h1);
    rd_chk(4'h2, 8'h00);
    do_op(CSFR_OP_ADD, 8'hF8, 8'h08, 3'h0, 1'b0);
    do_op(CSFR_OP_ADD, 8'h37, 8'h22, 3'h0, 1'b0);
    do_op(CSFR_OP_SUB, 8'h10, 8'h01, 3'h0, 1'b0);
    do_op(CSFR_OP_SUB, 8'h05, 8'h06, 3'h0, 1'b0);
    do_op(CSFR_OP_SUB, 8'h44, 8'h44, 3'h0, 1'b0);
    do_op(CSFR_OP_AND, 8'hF0, 8'h0F, 3'h0, 1'b0);
    do_op(CSFR_OP_IOR, 8'h01, 8'h00, 3'h0, 1'b0);
    do_op(CSFR_OP_XOR, 8'h5A, 8'h5A, 3'h0, 1'b0);
    do_op(CSFR_OP_ROR, 8'h02, 8'h00, 3'h0, 1'b0);
    do_op(CSFR_OP_ROL, 8'h80, 8'h00, 3'h0, 1'b0);
    do_op(CSFR_OP_ROR, 8'h01, 8'h00, 3'h0, 1'b0);
    do_op(CSFR_OP_NONE, 8'hFF, 8'hFF, 3'h0, 1'b1);
    do_op(CSFR_OP_STORE, 8'h00, 8'h45, 3'h0, 1'b1);
    do_op(CSFR_OP_BSET, exp_flag, 8'h00, 3'h7, 1'b1);
    do_op(CSFR_OP_BCLR, exp_flag, 8'h00, 3'h0, 1'b1);
    do_op(CSFR_OP_BSET, exp_flag, 8'h00, 3'h1, 1'b1);
    do_op(CSFR_OP_BSET, 8'h10, 8'h00, 3'h2, 1'b0);
    do_op(CSFR_OP_ZERO, 8'hFF, 8'h00, 3'h0, 1'b1);
    bus(1'b1, CSFR_OFS_EVENT, 8'h07, 4'h1);
    exp_ev = 3'h0;
    do_op(CSFR_OP_ADD, 8'hA1, 8'h01, 3'h0, 1'b1);
    rd_chk(CSFR_OFS_EVENT, {5'h00, exp_ev});
    rd_chk(CSFR_OFS_RESULT, exp_res);
    do_op(CSFR_OP_SLEEP, 8'h00, 8'h00, 3'h0, 1'b0);
    do_op(CSFR_OP_KICK, 8'h00, 8'h00, 3'h0, 1'b0);
    bus(1'b1, CSFR_OFS_MASK, 8'h01, 4'h1);
    chk(irq, 1'b0);
    wdog;
    chk(cpu_flag_register, exp_flag);
    chk(irq, 1'b1);
    rd_chk(CSFR_OFS_EVENT, {5'h00, exp_ev});
    bus(1'b1, CSFR_OFS_EVENT, 8'h01, 4'h1);
    exp_ev[0] = 1'b0;
    chk(irq, 1'b0);
    bus(1'b1, CSFR_OFS_MASK, 8'h02, 4'h1);
    chk(irq, 1'b1);
    rd_chk(CSFR_OFS_MASK, 8'h02);
    bus(1'b1, CSFR_OFS_EVENT, 8'h02, 4'h1);
    chk(irq, 1'b0);
    do_op(CSFR_OP_SLEEP, 8'h00, 8'h00, 3'h0, 1'b0);
    chk(irq, 1'b1);
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(cpu_flag_register, 8'h18);
    chk(irq, 1'b0);
    chk(op_done, 1'b0);
    chk(op_result, 8'h00);
    chk(avs_waitrequest, 1'b1);
    chk(avs_readdata, 32'h0000_0000);
    @(posedge clk_sys);
    resetn <= 1'b1;
    exp_flag = 8'h18;
    rd_chk(CSFR_OFS_FLAG, 8'h18);
    rd_chk(CSFR_OFS_EVENT, 8'h00);
    rd_chk(CSFR_OFS_MASK, 8'h00);
    give_verdict;
  end
endmodule
